// *** src/emu_option_pkg.sv ***
// Constants, addresses and state encodings shared by the option and port emulation logic.
package emu_option_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int PORT_W = 8;

    ////////////////////////////////////////////////////////////////////////////////
    // Register addresses.
    localparam logic [15:0] OVR_CTL_ADDR = 16'h0011;
    localparam logic [15:0] EE_CTL_ADDR = 16'h001C;
    localparam logic [15:0] FIRST_OPT_ADDR = 16'h3F00;
    localparam logic [15:0] SECOND_OPT_ADDR = 16'h3F01;
    localparam logic [15:0] WD_CLEAR_ADDR = 16'h3FF0;
    localparam logic [15:0] PORTC_DATA_ADDR = 16'h0002;
    localparam logic [15:0] PORTC_DIR_ADDR = 16'h0006;
    localparam logic [15:0] IRQ_STATUS_ADDR = 16'h0030;
    localparam logic [15:0] IRQ_MASK_ADDR = 16'h0031;
    localparam logic [15:0] EE_ARRAY_BASE = 16'h0080;

    localparam int EE_DEPTH = 128;
    localparam int EE_AW = 7;

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions.
    localparam int OVR_EN_BIT = 6;
    localparam int WD_CLEAR_BIT = 0;
    localparam int WD_EN_BIT = 0;
    localparam int PC7_BIT = 7;
    localparam int EE_PGM_BIT = 0;
    localparam int EE_LATCH_BIT = 1;
    localparam int IRQ_PORTA = 0;
    localparam int IRQ_WD = 1;
    localparam int IRQ_EE = 2;
    localparam int NUM_EVENTS = 3;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values.
    localparam logic OVR_EN_RESET = 1'b0;
    localparam logic PORTC_RESET = 1'b0;
    localparam logic [NUM_EVENTS-1:0] STATUS_RESET = 3'h0;
    localparam logic [NUM_EVENTS-1:0] MASK_RESET = 3'h0;
    localparam logic IRQ_LINE_RESET_B = 1'b1;

    ////////////////////////////////////////////////////////////////////////////////
    // Timing.
    localparam int CLK_PERIOD_PS = 4000;
    localparam int EE_PROG_TIME_US = 10;
    // Least time, so round up to whole cycles.
    localparam int EE_PROG_CYCLES = (EE_PROG_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WD_TIMEOUT_CYCLES = 65536;

    typedef enum logic [2:0] {
        EE_IDLE = 3'b001,
        EE_LATCHED = 3'b010,
        EE_BURN = 3'b100
    } ee_state_t;

endpackage

// *** src/eeprom_array.sv ***
// Flip-flop storage for the byte-programmable nonvolatile array.
`timescale 1ns/1ps
`default_nettype none
module eeprom_array #(
    parameter int DEPTH = 128,
    parameter int WIDTH = 8,
    parameter int AW = 7
) (
    input wire logic ref_clk, // Core clock.
    input wire logic writeEn, // Program one byte this cycle.
    input wire logic [AW-1:0] writeAddr, // Byte index to program.
    input wire logic [WIDTH-1:0] writeData, // Byte value to program.
    input wire logic [AW-1:0] readAddr, // Byte index to read.
    output logic [WIDTH-1:0] readData // Stored byte, combinational.
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
    } array_state_t;

    array_state_t q;
    array_state_t d;

    // Contents are nonvolatile, so reset leaves them alone.
    always_comb begin
        d = q;
        if (writeEn) begin
            d.mem[writeAddr] = writeData;
        end
    end

    always_ff @(posedge ref_clk) begin
        q <= d;
    end

    assign readData = q.mem[readAddr];
endmodule
`default_nettype wire

// *** src/option_port_emulation.sv ***
// Option byte override, watchdog clear, port A interrupt routing, port C bit 7 and array programming.
//
// How it works
// R1: Writing zero to bit 0 clears watchdog.
// R2: Option settings come from two option bytes.
// R3: First option starts at nonvolatile programmed value.
// R4: Bit 6 written to control enables override.
// R5: Override on: write to first option applies.
// R6: Override holds only while bit 6 stays set.
// R7: Reset or bit 6 cleared restores default.
// R8: Control register readback need not match writes.
// R9: Second option byte mirrors eight board switches.
// R10: Enabled input port A line low interrupts.
// R11: Port A interrupts use external interrupt line.
// R12: Software polls port A to find source.
// R13: A/D enabled: pin becomes high reference input.
// R14: Bit 7 registers stay accessible, pin unaffected.
// R15: A/D disabled: pin follows stored data, direction.
// R16: Software makes bit 7 input before A/D.
// R17: User code programs array byte-wise via register.
`timescale 1ns/1ps
`default_nettype none
module option_port_emulation #(
    parameter int WD_TIMEOUT = emu_option_pkg::WD_TIMEOUT_CYCLES,
    parameter int EE_PROG = emu_option_pkg::EE_PROG_CYCLES
) (
    input wire logic ref_clk, // Core clock, 250 MHz.
    input wire logic rst_b, // Synchronous reset, active low.
    input wire logic [emu_option_pkg::ADDR_W-1:0] busAddr, // Register address.
    input wire logic [emu_option_pkg::DATA_W-1:0] busWdata, // Write data.
    input wire logic busWrite, // Write strobe.
    input wire logic busRead, // Read strobe.
    output logic [emu_option_pkg::DATA_W-1:0] busRdata, // Read data, cycle after strobe.
    input wire logic [emu_option_pkg::DATA_W-1:0] firstOptionNv, // Programmed first option.
    input wire logic [emu_option_pkg::PORT_W-1:0] switchBankOn, // Switch bank, 1 = ON.
    input wire logic [emu_option_pkg::PORT_W-1:0] portAPin, // Port A pin levels.
    input wire logic [emu_option_pkg::PORT_W-1:0] portADirOut, // Port A direction, 1 = out.
    input wire logic extIrqPin_b, // External interrupt pin, low active.
    output logic irqRequest_b, // Merged interrupt line to the CPU.
    input wire logic adEnable, // A/D converter enabled.
    input wire logic pc7Pin, // Port C bit 7 pin level.
    output logic pc7Out, // Port C bit 7 drive value.
    output logic pc7Oe, // Port C bit 7 output enable.
    output logic highRefSelect, // Pin routed to high reference input.
    output logic watchdogReset, // One-cycle watchdog reset pulse.
    output logic [emu_option_pkg::DATA_W-1:0] activeFirstOption, // First option in force.
    output logic irq // Level interrupt, unmasked status set.
);
    import emu_option_pkg::*;

    localparam int WD_W = $clog2(WD_TIMEOUT + 1);
    localparam int EE_W = $clog2(EE_PROG + 1);
    localparam logic [WD_W-1:0] WD_LAST = WD_W'(WD_TIMEOUT - 1);
    localparam logic [EE_W-1:0] EE_LAST = EE_W'(EE_PROG - 1);

    typedef struct packed {
        logic [DATA_W-1:0] rdata;
        logic ovrEn;
        logic [DATA_W-1:0] firstOpt;
        logic [WD_W-1:0] wdCnt;
        logic wdRst;
        logic pcData;
        logic pcDir;
        logic pc7Out;
        logic pc7Oe;
        logic hiRef;
        logic irqB;
        logic portAReqPrev;
        ee_state_t eeState;
        logic eeHave;
        logic [EE_W-1:0] eeTimer;
        logic [EE_AW-1:0] eeAddr;
        logic [DATA_W-1:0] eeData;
        logic [NUM_EVENTS-1:0] status;
        logic [NUM_EVENTS-1:0] mask;
        logic irq;
    } state_t;

    state_t q;
    state_t d;

    logic portAReq;
    logic wdEnable;
    logic wdClear;
    logic eeCtlWrite;
    logic eeArrWrite;
    logic inArray;
    logic memWe;
    logic [DATA_W-1:0] arrRdata;
    logic [NUM_EVENTS-1:0] evSet;
    logic [NUM_EVENTS-1:0] evClr;

    eeprom_array #(
        .DEPTH(EE_DEPTH),
        .WIDTH(DATA_W),
        .AW(EE_AW)
    ) u_array (
        .ref_clk(ref_clk),
        .writeEn(memWe),
        .writeAddr(q.eeAddr),
        .writeData(q.eeData),
        .readAddr(busAddr[EE_AW-1:0]),
        .readData(arrRdata)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic.
    always_comb begin
        d = q;
        d.rdata = '0;
        d.wdRst = 1'b0;
        evSet = '0;
        evClr = '0;
        memWe = 1'b0;
        inArray = (busAddr[ADDR_W-1:EE_AW] == EE_ARRAY_BASE[ADDR_W-1:EE_AW]);
        eeCtlWrite = busWrite && (busAddr == EE_CTL_ADDR);
        eeArrWrite = busWrite && inArray;

        // Watchdog runs only when the active first option enables it.
        wdEnable = q.firstOpt[WD_EN_BIT];
        wdClear = busWrite && (busAddr == WD_CLEAR_ADDR) && !busWdata[WD_CLEAR_BIT]; // R1
        if (!wdEnable || wdClear || q.wdRst) begin
            d.wdCnt = '0; // R1
        end else if (q.wdCnt == WD_LAST) begin
            d.wdCnt = '0;
            d.wdRst = 1'b1; // R1
            evSet[IRQ_WD] = 1'b1;
        end else begin
            d.wdCnt = q.wdCnt + 1'b1;
        end

        // Override control; bit 6 alone keeps the override alive.
        if (busWrite && (busAddr == OVR_CTL_ADDR)) begin
            d.ovrEn = busWdata[OVR_EN_BIT]; // R4 R6
            if (!busWdata[OVR_EN_BIT]) begin
                d.firstOpt = firstOptionNv; // R7
            end
        end
        // Uses the enable already in force, so arming and writing take two accesses.
        if (busWrite && (busAddr == FIRST_OPT_ADDR) && q.ovrEn) begin
            d.firstOpt = busWdata; // R5
        end
        // A watchdog reset is a reset like any other for the override.
        if (q.wdRst) begin
            d.ovrEn = OVR_EN_RESET; // R7
            d.firstOpt = firstOptionNv; // R7
        end

        ////////////////////////////////////////////////////////////////////////////////
        // Port A interrupts are merged onto the external request line, so the CPU
        // cannot tell them apart and must poll the port to find the source.
        portAReq = |(switchBankOn & ~portADirOut & ~portAPin); // R10
        d.irqB = extIrqPin_b && !portAReq; // R11
        d.portAReqPrev = portAReq;
        if (portAReq && !q.portAReqPrev) begin
            evSet[IRQ_PORTA] = 1'b1;
        end

        ////////////////////////////////////////////////////////////////////////////////
        // Port C bit 7: registers always accessible, pin released while A/D owns it.
        if (busWrite && (busAddr == PORTC_DATA_ADDR)) begin
            d.pcData = busWdata[PC7_BIT]; // R14
        end
        if (busWrite && (busAddr == PORTC_DIR_ADDR)) begin
            d.pcDir = busWdata[PC7_BIT]; // R14
        end
        d.hiRef = adEnable; // R13
        d.pc7Oe = !adEnable && q.pcDir; // R13 R15
        d.pc7Out = q.pcData; // R15

        ////////////////////////////////////////////////////////////////////////////////
        // Array programming: latch, write the target byte, then set program.
        case (q.eeState)
            EE_IDLE: begin
                d.eeHave = 1'b0;
                if (eeCtlWrite && busWdata[EE_LATCH_BIT] && !busWdata[EE_PGM_BIT]) begin
                    d.eeState = EE_LATCHED; // R17
                end
            end
            EE_LATCHED: begin
                if (eeArrWrite) begin
                    d.eeAddr = busAddr[EE_AW-1:0]; // R17
                    d.eeData = busWdata;
                    d.eeHave = 1'b1;
                end
                if (eeCtlWrite) begin
                    if (!busWdata[EE_LATCH_BIT]) begin
                        d.eeState = EE_IDLE;
                    end else if (busWdata[EE_PGM_BIT] && q.eeHave) begin
                        d.eeState = EE_BURN; // R17
                        d.eeTimer = EE_LAST;
                    end
                end
            end
            EE_BURN: begin
                // Control writes are ignored until the byte is done.
                if (q.eeTimer == '0) begin
                    memWe = 1'b1; // R17
                    d.eeState = EE_IDLE;
                    evSet[IRQ_EE] = 1'b1;
                end else begin
                    d.eeTimer = q.eeTimer - 1'b1;
                end
            end
            default: begin
                d.eeState = EE_IDLE;
            end
        endcase

        ////////////////////////////////////////////////////////////////////////////////
        // Sticky status; a new event beats a clear in the same cycle.
        if (busWrite && (busAddr == IRQ_STATUS_ADDR)) begin
            evClr = busWdata[NUM_EVENTS-1:0];
        end
        if (busWrite && (busAddr == IRQ_MASK_ADDR)) begin
            d.mask = busWdata[NUM_EVENTS-1:0];
        end
        d.status = (q.status & ~evClr) | evSet;
        d.irq = |(d.status & d.mask);

        ////////////////////////////////////////////////////////////////////////////////
        // Read data stands only in the cycle after the strobe.
        if (busRead) begin
            if (inArray) begin
                d.rdata = arrRdata;
            end else begin
                case (busAddr)
                    // Write-only; verify after a write is expected to mismatch.
                    OVR_CTL_ADDR: d.rdata = '0; // R8
                    EE_CTL_ADDR: begin
                        d.rdata = '0;
                        d.rdata[EE_LATCH_BIT] = (q.eeState != EE_IDLE);
                        d.rdata[EE_PGM_BIT] = (q.eeState == EE_BURN);
                    end
                    FIRST_OPT_ADDR: d.rdata = q.firstOpt; // R2
                    SECOND_OPT_ADDR: d.rdata = switchBankOn; // R2 R9
                    PORTC_DATA_ADDR: begin
                        d.rdata = '0;
                        // Pin level is hidden while it serves as reference input.
                        d.rdata[PC7_BIT] = (adEnable || q.pcDir) ? q.pcData : pc7Pin; // R13
                    end
                    PORTC_DIR_ADDR: begin
                        d.rdata = '0;
                        d.rdata[PC7_BIT] = q.pcDir; // R14
                    end
                    IRQ_STATUS_ADDR: d.rdata = DATA_W'(q.status);
                    IRQ_MASK_ADDR: d.rdata = DATA_W'(q.mask);
                    default: d.rdata = '0;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            q <= '0;
            q.ovrEn <= OVR_EN_RESET;
            q.firstOpt <= firstOptionNv; // R3 R7
            q.pcData <= PORTC_RESET;
            q.pcDir <= PORTC_RESET;
            q.irqB <= IRQ_LINE_RESET_B;
            q.eeState <= EE_IDLE;
            q.status <= STATUS_RESET;
            q.mask <= MASK_RESET;
        end else begin
            q <= d;
        end
    end

    assign busRdata = q.rdata;
    assign irqRequest_b = q.irqB;
    assign pc7Out = q.pc7Out;
    assign pc7Oe = q.pc7Oe;
    assign highRefSelect = q.hiRef;
    assign watchdogReset = q.wdRst;
    assign activeFirstOption = q.firstOpt;
    assign irq = q.irq;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.
    property p_wdClear;
        @(posedge ref_clk) disable iff (!rst_b)
        (busWrite && busAddr == WD_CLEAR_ADDR && !busWdata[WD_CLEAR_BIT]) |=> (q.wdCnt == '0);
    endproperty
    a_wdClear: assert property (p_wdClear) else $error("watchdog not cleared"); // R1

    property p_wdBite;
        @(posedge ref_clk) disable iff (!rst_b)
        (q.firstOpt[WD_EN_BIT] && q.wdCnt == WD_LAST && !wdClear)
            |=> (watchdogReset ##1 (!watchdogReset && activeFirstOption == $past(firstOptionNv)));
    endproperty
    a_wdBite: assert property (p_wdBite) else $error("watchdog reset missing"); // R1

    sequence s_ovrArm;
        busWrite && busAddr == OVR_CTL_ADDR && busWdata[OVR_EN_BIT] && !q.wdRst;
    endsequence
    sequence s_optWrite;
        busWrite && busAddr == FIRST_OPT_ADDR && !q.wdRst;
    endsequence
    property p_ovrApply;
        @(posedge ref_clk) disable iff (!rst_b)
        s_ovrArm ##1 s_optWrite |=> (activeFirstOption == $past(busWdata));
    endproperty
    a_ovrApply: assert property (p_ovrApply) else $error("override write not applied"); // R5

    property p_ovrLocked;
        @(posedge ref_clk) disable iff (!rst_b)
        (!q.ovrEn && !(busWrite && busAddr == OVR_CTL_ADDR) && !q.wdRst)
            |=> (activeFirstOption == $past(activeFirstOption));
    endproperty
    a_ovrLocked: assert property (p_ovrLocked) else $error("option changed without override"); // R6

    property p_ovrRevert;
        @(posedge ref_clk) disable iff (!rst_b)
        (busWrite && busAddr == OVR_CTL_ADDR && !busWdata[OVR_EN_BIT])
            |=> (!q.ovrEn && activeFirstOption == $past(firstOptionNv));
    endproperty
    a_ovrRevert: assert property (p_ovrRevert) else $error("option not restored"); // R7

    property p_switchRead;
        @(posedge ref_clk) disable iff (!rst_b)
        (busRead && busAddr == SECOND_OPT_ADDR) |=> (busRdata == $past(switchBankOn));
    endproperty
    a_switchRead: assert property (p_switchRead) else $error("second option mismatch"); // R9

    property p_portAIrq;
        @(posedge ref_clk) disable iff (!rst_b)
        (|(switchBankOn & ~portADirOut & ~portAPin)) |=> !irqRequest_b;
    endproperty
    a_portAIrq: assert property (p_portAIrq) else $error("port A interrupt lost"); // R10 R11

    property p_refPin;
        @(posedge ref_clk) disable iff (!rst_b)
        adEnable |=> (highRefSelect && !pc7Oe);
    endproperty
    a_refPin: assert property (p_refPin) else $error("pin driven while reference"); // R13 R14

    property p_pinRestore;
        @(posedge ref_clk) disable iff (!rst_b)
        !adEnable |=> (pc7Oe == $past(q.pcDir) && pc7Out == $past(q.pcData) && !highRefSelect);
    endproperty
    a_pinRestore: assert property (p_pinRestore) else $error("pin not restored"); // R15

    property p_eeDone;
        @(posedge ref_clk) disable iff (!rst_b)
        (q.eeState == EE_BURN && q.eeTimer == '0)
            |=> (q.eeState == EE_IDLE && q.status[IRQ_EE]);
    endproperty
    a_eeDone: assert property (p_eeDone) else $error("program cycle did not finish"); // R17
endmodule
`default_nettype wire

// *** verification/target_pins_model.sv ***
// Target side model: rebuilt port A with pullups, external interrupt pin and port C bit 7 pin.
`timescale 1ns/1ps
`default_nettype none
module target_pins_model (
    input wire logic [7:0] lineLowReq, // Port A lines the target pulls low.
    input wire logic extLow, // Target asserts the external interrupt.
    input wire logic pc7Level, // Level the target puts on the shared pin.
    input wire logic pc7Out, // Device drive value for the shared pin.
    input wire logic pc7Oe, // Device drives the shared pin.
    output logic [7:0] portAPin, // Port A pin levels.
    output logic extIrqPin_b, // External interrupt pin, low active.
    output logic pc7Pin // Resolved shared pin level.
);
    // Released port A lines float up through their pullups.
    assign portAPin = ~lineLowReq;
    assign extIrqPin_b = ~extLow;
    // The device wins the shared pin only while its enable is high.
    assign pc7Pin = pc7Oe ? pc7Out : pc7Level;
endmodule
`default_nettype wire

// *** verification/option_port_emulation_bench.sv ***
// Self-checking bench for the option override and port emulation block.
`timescale 1ns/1ps
`default_nettype none
module option_port_emulation_bench;
    import emu_option_pkg::*;
    localparam int WD_T = 16;
    localparam int EE_T = 4;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [15:0] busAddr = 16'h0000;
    logic [7:0] busWdata = 8'h00;
    logic busWrite = 1'b0;
    logic busRead = 1'b0;
    logic [7:0] nvOpt = 8'h24;
    logic [7:0] switches = 8'hF0;
    logic [7:0] dirOut = 8'h00;
    logic [7:0] lowReq = 8'h00;
    logic extLow = 1'b0;
    logic adEn = 1'b0;
    logic pc7Level = 1'b1;
    logic [7:0] busRdata, portAPin, activeFirstOption, r, d;
    logic extIrqPin_b, irqRequest_b, pc7Pin, pc7Out, pc7Oe, highRefSelect, watchdogReset, irq;
    int failures = 0;
    int samples_checked = 0;
    int wdPulses = 0;
    int n;

    option_port_emulation #(.WD_TIMEOUT(WD_T), .EE_PROG(EE_T)) option_port_emulation_inst (
        .ref_clk(ref_clk), .rst_b(rst_b), .busAddr(busAddr), .busWdata(busWdata),
        .busWrite(busWrite), .busRead(busRead), .busRdata(busRdata),
        .firstOptionNv(nvOpt), .switchBankOn(switches), .portAPin(portAPin),
        .portADirOut(dirOut), .extIrqPin_b(extIrqPin_b), .irqRequest_b(irqRequest_b),
        .adEnable(adEn), .pc7Pin(pc7Pin), .pc7Out(pc7Out), .pc7Oe(pc7Oe),
        .highRefSelect(highRefSelect), .watchdogReset(watchdogReset),
        .activeFirstOption(activeFirstOption), .irq(irq));

    target_pins_model target_pins_model_inst (
        .lineLowReq(lowReq), .extLow(extLow), .pc7Level(pc7Level), .pc7Out(pc7Out),
        .pc7Oe(pc7Oe), .portAPin(portAPin), .extIrqPin_b(extIrqPin_b), .pc7Pin(pc7Pin));

    initial begin
        forever #2 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        if (watchdogReset === 1'b1) begin
            wdPulses <= wdPulses + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk1(input string what, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic conclude();
        $display("failures %0d samples_checked %0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Each access leaves one idle cycle behind it, so a strobe is never set twice in a step.
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        busAddr <= a;
        busWdata <= v;
        busWrite <= 1'b1;
        @(posedge ref_clk);
        busWrite <= 1'b0;
    endtask

    // Two writes with no gap, so the strobe stays high across both edges.
    task automatic wrPair(input logic [15:0] a0, input logic [7:0] v0,
                          input logic [15:0] a1, input logic [7:0] v1);
        @(posedge ref_clk);
        busAddr <= a0;
        busWdata <= v0;
        busWrite <= 1'b1;
        @(posedge ref_clk);
        busAddr <= a1;
        busWdata <= v1;
        @(posedge ref_clk);
        busWrite <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, output logic [7:0] v);
        @(posedge ref_clk);
        busAddr <= a;
        busRead <= 1'b1;
        @(posedge ref_clk);
        busRead <= 1'b0;
        #1;
        v = busRdata;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask

    initial begin
        #100000;
        failures++;
        conclude();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge ref_clk);
        rst_b <= 1'b1;
        cyc(1);
        chk8("active option", 8'h24, activeFirstOption);
        rd(SECOND_OPT_ADDR, r);
        chk8("second option", 8'hF0, r);
        rd(16'h0040, r);
        chk8("unmapped read", 8'h00, r);
        // A store to the first option without the override armed must not land.
        wr(FIRST_OPT_ADDR, 8'h80);
        cyc(1);
        chk8("active option", 8'h24, activeFirstOption);
        wr(OVR_CTL_ADDR, 8'h40);
        rd(OVR_CTL_ADDR, r);
        chk8("override readback", 8'h00, r);
        wr(FIRST_OPT_ADDR, 8'h80);
        cyc(1);
        chk8("active option", 8'h80, activeFirstOption);
        wr(OVR_CTL_ADDR, 8'h00);
        cyc(1);
        chk8("active option", 8'h24, activeFirstOption);
        wr(FIRST_OPT_ADDR, 8'hC0);
        cyc(1);
        chk8("active option", 8'h24, activeFirstOption);
        wrPair(OVR_CTL_ADDR, 8'h40, FIRST_OPT_ADDR, 8'h80);
        cyc(1);
        chk8("active option", 8'h80, activeFirstOption);
        nvOpt <= 8'h26;
        @(posedge ref_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        cyc(1);
        chk8("active option", 8'h26, activeFirstOption);
        // Watchdog armed through the override; regular clears keep it quiet.
        wr(IRQ_MASK_ADDR, 8'h07);
        wrPair(OVR_CTL_ADDR, 8'h40, FIRST_OPT_ADDR, 8'h81);
        repeat (12) wr(WD_CLEAR_ADDR, 8'h00);
        chk8("watchdog pulses", 8'h00, 8'(wdPulses));
        n = 0;
        while (wdPulses == 0 && n < 40) begin
            cyc(1);
            n++;
        end
        chk8("watchdog pulses", 8'h01, 8'(wdPulses));
        cyc(2);
        chk8("active option", 8'h26, activeFirstOption);
        chk1("irq", 1'b1, irq);
        rd(IRQ_STATUS_ADDR, r);
        chk8("status", 8'h02, r & 8'h07);
        wr(IRQ_STATUS_ADDR, 8'h02);
        cyc(1);
        chk1("irq", 1'b0, irq);
        // Port A: switch off, line as output, then a live line, then the external pin.
        lowReq <= 8'h02;
        cyc(3);
        chk1("irq line", 1'b1, irqRequest_b);
        dirOut <= 8'h20;
        lowReq <= 8'h20;
        cyc(3);
        chk1("irq line", 1'b1, irqRequest_b);
        dirOut <= 8'h00;
        cyc(3);
        chk1("irq line", 1'b0, irqRequest_b);
        chk1("irq", 1'b1, irq);
        chk8("polled lines", 8'hDF, portAPin | 8'h0F);
        rd(IRQ_STATUS_ADDR, r);
        chk8("status", 8'h01, r & 8'h07);
        lowReq <= 8'h00;
        wr(IRQ_STATUS_ADDR, 8'h01);
        cyc(2);
        chk1("irq line", 1'b1, irqRequest_b);
        chk1("irq", 1'b0, irq);
        wr(IRQ_MASK_ADDR, 8'h06);
        lowReq <= 8'h10;
        cyc(3);
        chk1("masked irq", 1'b0, irq);
        lowReq <= 8'h00;
        extLow <= 1'b1;
        cyc(3);
        chk1("irq line", 1'b0, irqRequest_b);
        extLow <= 1'b0;
        wr(IRQ_STATUS_ADDR, 8'h07);
        // Shared port C bit 7 pin.
        wr(PORTC_DIR_ADDR, 8'h80);
        wr(PORTC_DATA_ADDR, 8'h80);
        cyc(2);
        chk1("pc7 enable", 1'b1, pc7Oe);
        chk1("pc7 drive", 1'b1, pc7Out);
        wr(PORTC_DIR_ADDR, 8'h00);
        adEn <= 1'b1;
        wr(PORTC_DIR_ADDR, 8'h80);
        wr(PORTC_DATA_ADDR, 8'h00);
        cyc(2);
        chk1("pc7 enable", 1'b0, pc7Oe);
        chk1("reference select", 1'b1, highRefSelect);
        rd(PORTC_DATA_ADDR, r);
        chk8("pc7 data", 8'h00, r & 8'h80);
        rd(PORTC_DIR_ADDR, r);
        chk8("pc7 direction", 8'h80, r & 8'h80);
        adEn <= 1'b0;
        cyc(3);
        chk1("pc7 enable", 1'b1, pc7Oe);
        chk1("pc7 drive", 1'b0, pc7Out);
        chk1("reference select", 1'b0, highRefSelect);
        wr(PORTC_DIR_ADDR, 8'h00);
        rd(PORTC_DATA_ADDR, r);
        chk8("pc7 data", 8'h80, r & 8'h80);
        // Byte programming at both ends of the array; the last data store counts.
        for (int i = 0; i < 128; i += 127) begin
            d = 8'h5A ^ 8'(i);
            wr(EE_CTL_ADDR, 8'h02);
            wr(EE_ARRAY_BASE + 16'(i), 8'hFF);
            wr(EE_ARRAY_BASE + 16'(i), d);
            wr(EE_CTL_ADDR, 8'h03);
            rd(EE_CTL_ADDR, r);
            chk8("program control", 8'h03, r & 8'h03);
            n = 0;
            while (r !== 8'h00 && n < 20) begin
                rd(EE_CTL_ADDR, r);
                n++;
            end
            chk8("program control", 8'h00, r);
            rd(EE_ARRAY_BASE + 16'(i), r);
            chk8("array byte", d, r);
            rd(IRQ_STATUS_ADDR, r);
            chk8("status", 8'h04, r & 8'h07);
            wr(IRQ_STATUS_ADDR, 8'h04);
        end
        // Program without a data store is ignored; clearing the latch aborts.
        wr(EE_CTL_ADDR, 8'h02);
        wr(EE_CTL_ADDR, 8'h03);
        rd(EE_CTL_ADDR, r);
        chk8("program control", 8'h02, r);
        wr(EE_CTL_ADDR, 8'h00);
        rd(EE_CTL_ADDR, r);
        chk8("program control", 8'h00, r);
        conclude();
    end
endmodule
`default_nettype wire
